// File: rtl/scs_map.vh
// Constants for the sensorless commutation sequencer.
// Ramp levels are in millivolt-like units and steps in units per clock, keeping the analog ratios.
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// Common ramp counter width.
`define SCS_RAMP_W        12

// Start oscillator: equal up and down rates between its two thresholds.
`define SCS_ST_LO         12'h032
`define SCS_ST_HI         12'h898
`define SCS_ST_STEP       12'h001

// Delay measurer: charge at one rate, discharge at twice that rate.
`define SCS_CD_LO         12'h384
`define SCS_CD_HI         12'h898
`define SCS_CD_UP_STEP    12'h001
`define SCS_CD_DN_STEP    12'h002

// Delay repeater: equal charge and discharge rates.
`define SCS_DC_STEP       12'h002

// Step watchdog timer: fast ramp, slow watchdog ramp, discharge.
`define SCS_TI_LO         12'h0C8
`define SCS_TI_MID        12'h12C
`define SCS_TI_HI         12'h898
`define SCS_TI_FAST_STEP  12'h039
`define SCS_TI_SLOW_STEP  12'h005
`define SCS_TI_DN_STEP    12'h01C

// Commutation state codes.
`define SCS_S1            3'h1
`define SCS_S6            3'h6

`endif

// File: rtl/scs_ramp.v
// Saturating up/down counter standing in for one capacitor ramp.
// Assumes one clock; clear loads the lower level, up and down are never both set.
`timescale 1ns/1ps
`default_nettype none

module scs_ramp #(
    parameter integer W  = 12,
    parameter [W-1:0] LO = 12'h000,
    parameter [W-1:0] HI = 12'hFFF
) (
    input  wire         i_sys_clk,  // System clock.
    input  wire         i_rst,      // Synchronous reset, active high.
    input  wire         i_clear,    // Load the lower level.
    input  wire         i_up,       // Ramp up this cycle.
    input  wire         i_dn,       // Ramp down this cycle.
    input  wire [W-1:0] i_up_step,  // Increment per cycle.
    input  wire [W-1:0] i_dn_step,  // Decrement per cycle.
    output wire [W-1:0] o_count,    // Present level.
    output wire         o_at_lo,    // Level at or below the lower limit.
    output wire         o_at_hi     // Level at or above the upper limit.
);

    reg  [W-1:0] cnt_ff;
    reg  [W-1:0] nxt_cnt;
    wire [W:0]   sum_up;
    wire [W:0]   diff_dn;

    assign sum_up  = {1'b0, cnt_ff} + {1'b0, i_up_step};
    assign diff_dn = {1'b0, cnt_ff} - {1'b0, i_dn_step};

    // Next level, clamped to the two limits so a ramp never wraps.
    always @* begin
        nxt_cnt = cnt_ff;
        if (i_clear) begin
            nxt_cnt = LO;
        end else if (i_up) begin
            nxt_cnt = (sum_up >= {1'b0, HI}) ? HI : sum_up[W-1:0];
        end else if (i_dn) begin
            nxt_cnt = (diff_dn[W] || diff_dn <= {1'b0, LO}) ? LO : diff_dn[W-1:0];
        end
    end

    // Level register.
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_ff <= LO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_count = cnt_ff;
    assign o_at_lo = (cnt_ff <= LO);
    assign o_at_hi = (cnt_ff >= HI);

endmodule

`default_nettype wire

// File: rtl/scs_sequencer.v
// Sensorless six-state commutation sequencer with adaptive delay, start oscillator and watchdog.
// Assumes comparator, flyback and control inputs are synchronous to i_sys_clk.
//
// Operation
// R1: Six states, each one phase high, one low, one floating, fixed order.
// R2: Only the floating phase comparator feeds zero-crossing detection.
// R3: A zero-crossing starts a delay; its end advances the state.
// R4: Tacho output toggles on every detected zero-crossing.
// R5: Start oscillator steps when crossings are absent; every commutation restarts it.
// R6: Each start pulse advances exactly one state.
// R7: Start period is one full up-and-down ramp at equal rates.
// R8: Measurer ramps up one period, pausing in flyback, then down twice as fast.
// R9: Out-of-range measurer gives the fixed full-ramp-down maximum delay.
// R10: Repeater ramps up and down equally to give alternate periods the same delay.
// R11: After flyback, fast ramp, then slow watchdog ramp only while EMF polarity wrong.
// R12: Watchdog end or EMF recovery ramps the step timer back to its start.
// R13: Watchdog expiry blocks zero-crossings and leaves stepping to the start oscillator.
// R14: Each capacitor ramp is an up/down counter with ratio-keeping parameters.
// R15: Low direction runs forward order, high direction runs reverse order.
// R16: Brake drives all phases low and overrides reset.
// R17: Reset without brake holds state 1: a floating, b low, c high.
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.vh"

module scs_sequencer #(
    parameter integer         W     = `SCS_RAMP_W,
    parameter [`SCS_RAMP_W-1:0] ST_STEP = `SCS_ST_STEP
) (
    input  wire i_sys_clk,            // System clock, 50 MHz.
    input  wire i_rst,                // Synchronous reset, active high.
    input  wire i_brake,              // Brake request, active high.
    input  wire i_hold_reset,         // Sequence reset request, active high.
    input  wire i_dir,                // Direction: low forward, high reverse.
    input  wire i_flyback,            // Flyback diode pulse present, active high.
    input  wire i_emf_a,              // Back-EMF comparator of phase a.
    input  wire i_emf_b,              // Back-EMF comparator of phase b.
    input  wire i_emf_c,              // Back-EMF comparator of phase c.
    output wire o_phase_out_a,        // Phase a level when driven.
    output wire o_phase_out_a_oe_n,   // Phase a drive enable, low while driven.
    output wire o_phase_out_b,        // Phase b level when driven.
    output wire o_phase_out_b_oe_n,   // Phase b drive enable, low while driven.
    output wire o_phase_out_c,        // Phase c level when driven.
    output wire o_phase_out_c_oe_n,   // Phase c drive enable, low while driven.
    output wire o_tacho_toggle_out,   // Tacho level, toggles per crossing.
    output wire o_commutate,          // One-cycle pulse on every state advance.
    output wire o_watchdog_expired    // Level, watchdog ran out this period.
);

    // Step timer phases.
    localparam [2:0] T_FLY  = 3'h0;
    localparam [2:0] T_FAST = 3'h1;
    localparam [2:0] T_WDOG = 3'h2;
    localparam [2:0] T_DOWN = 3'h3;
    localparam [2:0] T_ARM  = 3'h4;
    localparam [2:0] T_WAIT = 3'h5;

    reg  [2:0]   state_ff;
    reg  [2:0]   nxt_state;
    reg  [2:0]   tmr_ff;
    reg  [2:0]   nxt_tmr;
    reg          par_ff;
    reg          dly_ff;
    reg          no_emf_ff;
    reg          tacho_ff;
    reg          st_up_ff;
    reg  [2:0]   lvl_ff;
    reg  [2:0]   oe_n_ff;
    reg  [2:0]   hi_mask;
    reg  [2:0]   z_mask;
    reg          sel_emf;
    reg          zc;
    reg          wd_expire;
    wire         hold;
    wire         rising;
    wire         aligned;
    wire         dly_end;
    wire         st_pulse;
    wire         commute;
    wire [W-1:0] st_cnt;
    wire         st_lo;
    wire         st_hi;
    wire         cd_lo;
    wire         dc_lo;
    wire [W-1:0] ti_cnt;
    wire         ti_lo;
    wire         ti_hi;

    assign hold = i_brake | i_hold_reset;

    // Floating phase comparator selection per state.
    always @* begin
        case (state_ff)
            3'h1, 3'h4: sel_emf = i_emf_a;  // [R2]
            3'h2, 3'h5: sel_emf = i_emf_c;  // [R2]
            3'h3, 3'h6: sel_emf = i_emf_b;  // [R2]
            default:    sel_emf = 1'b0;
        endcase
    end

    // Expected EMF slope of the floating phase; aligned means past-crossing polarity.
    assign rising  = state_ff[0] ^ i_dir;
    assign aligned = ~(sel_emf ^ rising);

    // Delay ends when the ramp used this period reaches its lower level.
    assign dly_end  = dly_ff & (par_ff ? cd_lo : dc_lo);                  // [R3] [R10]
    assign st_pulse = ~st_up_ff & st_lo & ~hold;                          // [R7]
    assign commute  = ~hold & (dly_end | st_pulse);                       // [R3] [R6]

    // Next commutation state in the selected direction.
    always @* begin
        nxt_state = state_ff;
        if (hold) begin
            nxt_state = `SCS_S1;                                          // [R17]
        end else if (commute) begin
            if (i_dir) begin
                nxt_state = (state_ff == `SCS_S1) ? `SCS_S6 : state_ff - 3'h1;  // [R15]
            end else begin
                nxt_state = (state_ff == `SCS_S6) ? `SCS_S1 : state_ff + 3'h1;  // [R1] [R15]
            end
        end
    end

    // Step timer sequence within one commutation period.
    always @* begin
        nxt_tmr   = tmr_ff;
        zc        = 1'b0;
        wd_expire = 1'b0;
        case (tmr_ff)
            T_FLY: begin
                if (!i_flyback) begin
                    nxt_tmr = T_FAST;
                end
            end
            T_FAST: begin
                if (ti_cnt >= `SCS_TI_MID) begin
                    nxt_tmr = T_WDOG;                                     // [R11]
                end
            end
            T_WDOG: begin
                if (!aligned) begin
                    nxt_tmr = T_DOWN;                                     // [R12]
                end else if (ti_hi) begin
                    nxt_tmr   = T_DOWN;                                   // [R12]
                    wd_expire = 1'b1;
                end
            end
            T_DOWN: begin
                if (ti_lo) begin
                    nxt_tmr = T_ARM;
                end
            end
            T_ARM: begin
                if (aligned && !no_emf_ff) begin
                    zc      = 1'b1;                                       // [R2] [R13]
                    nxt_tmr = T_WAIT;
                end
            end
            T_WAIT: begin
                nxt_tmr = T_WAIT;
            end
            default: begin
                nxt_tmr = T_FLY;
            end
        endcase
        if (hold || commute) begin
            nxt_tmr = T_FLY;
            zc      = 1'b0;
        end
    end

    // Sequence, period parity, delay, watchdog and tacho registers.
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_ff  <= `SCS_S1;
            tmr_ff    <= T_FLY;
            par_ff    <= 1'b0;
            dly_ff    <= 1'b0;
            no_emf_ff <= 1'b0;
            tacho_ff  <= 1'b0;
            st_up_ff  <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
            if (hold) begin
                par_ff    <= 1'b0;
                dly_ff    <= 1'b0;
                no_emf_ff <= 1'b0;
                st_up_ff  <= 1'b1;
            end else begin
                if (commute) begin
                    par_ff    <= ~par_ff;                                 // [R8]
                    dly_ff    <= 1'b0;
                    no_emf_ff <= 1'b0;
                    st_up_ff  <= 1'b1;                                    // [R5]
                end else begin
                    if (zc) begin
                        dly_ff <= 1'b1;                                   // [R3]
                    end
                    if (wd_expire) begin
                        no_emf_ff <= 1'b1;                                // [R13]
                    end
                    if (st_up_ff && st_hi) begin
                        st_up_ff <= 1'b0;                                 // [R7]
                    end else if (!st_up_ff && st_lo) begin
                        st_up_ff <= 1'b1;
                    end
                end
                if (zc) begin
                    tacho_ff <= ~tacho_ff;                                // [R4]
                end
            end
        end
    end

    // Start oscillator ramp, restarted by every commutation.
    scs_ramp #(.W(W), .LO(`SCS_ST_LO), .HI(`SCS_ST_HI)) u_start_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clear   (hold | commute),                                      // [R5]
        .i_up      (st_up_ff),
        .i_dn      (~st_up_ff),
        .i_up_step (ST_STEP),                                             // [R7] [R14]
        .i_dn_step (ST_STEP),
        .o_count   (st_cnt),
        .o_at_lo   (st_lo),
        .o_at_hi   (st_hi)
    );

    // Delay measurer: charges in even periods outside flyback, discharges after the crossing.
    scs_ramp #(.W(W), .LO(`SCS_CD_LO), .HI(`SCS_CD_HI)) u_delay_measurer (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clear   (hold | (commute & par_ff)),
        .i_up      (~par_ff & ~i_flyback),                                // [R8]
        .i_dn      (par_ff & dly_ff),                                     // [R8] [R9]
        .i_up_step (`SCS_CD_UP_STEP),                                     // [R14]
        .i_dn_step (`SCS_CD_DN_STEP),
        .o_count   (),
        .o_at_lo   (cd_lo),
        .o_at_hi   ()
    );

    // Delay repeater: copies the measured delay and replays it in the next period.
    scs_ramp #(.W(W), .LO(`SCS_CD_LO), .HI(`SCS_CD_HI)) u_delay_repeater (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clear   (hold | (commute & ~par_ff)),
        .i_up      (par_ff & dly_ff),                                     // [R10]
        .i_dn      (~par_ff & dly_ff),                                    // [R10]
        .i_up_step (`SCS_DC_STEP),                                        // [R14]
        .i_dn_step (`SCS_DC_STEP),
        .o_count   (),
        .o_at_lo   (dc_lo),
        .o_at_hi   ()
    );

    // Step watchdog timer: fast ramp, slow watchdog ramp, then discharge.
    scs_ramp #(.W(W), .LO(`SCS_TI_LO), .HI(`SCS_TI_HI)) u_step_watchdog_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clear   (hold | commute),
        .i_up      ((tmr_ff == T_FAST) | ((tmr_ff == T_WDOG) & aligned)),  // [R11]
        .i_dn      (tmr_ff == T_DOWN),                                    // [R12]
        .i_up_step ((tmr_ff == T_FAST) ? `SCS_TI_FAST_STEP : `SCS_TI_SLOW_STEP),  // [R14]
        .i_dn_step (`SCS_TI_DN_STEP),
        .o_count   (ti_cnt),
        .o_at_lo   (ti_lo),
        .o_at_hi   (ti_hi)
    );

    // Drive pattern of the next state; bit 0 is phase a, bit 2 is phase c.
    always @* begin
        case (nxt_state)
            3'h1:    begin hi_mask = 3'h4; z_mask = 3'h1; end  // [R1] [R17]
            3'h2:    begin hi_mask = 3'h1; z_mask = 3'h4; end  // [R1]
            3'h3:    begin hi_mask = 3'h1; z_mask = 3'h2; end  // [R1]
            3'h4:    begin hi_mask = 3'h2; z_mask = 3'h1; end  // [R1]
            3'h5:    begin hi_mask = 3'h2; z_mask = 3'h4; end  // [R1]
            3'h6:    begin hi_mask = 3'h4; z_mask = 3'h2; end  // [R1]
            default: begin hi_mask = 3'h0; z_mask = 3'h0; end
        endcase
        if (i_brake) begin
            hi_mask = 3'h0;                                               // [R16]
            z_mask  = 3'h0;                                               // [R16]
        end
    end

    // Registered phase drive.
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            lvl_ff  <= 3'h4;
            oe_n_ff <= 3'h1;
        end else begin
            lvl_ff  <= hi_mask;
            oe_n_ff <= z_mask;
        end
    end

    assign o_phase_out_a      = lvl_ff[0];
    assign o_phase_out_a_oe_n = oe_n_ff[0];
    assign o_phase_out_b      = lvl_ff[1];
    assign o_phase_out_b_oe_n = oe_n_ff[1];
    assign o_phase_out_c      = lvl_ff[2];
    assign o_phase_out_c_oe_n = oe_n_ff[2];
    assign o_tacho_toggle_out = tacho_ff;
    assign o_commutate        = commute;
    assign o_watchdog_expired = no_emf_ff;

endmodule

`default_nettype wire

// File: tb/scs_sequencer_assertions.sv
// Checker of the sequencer ports: output codes, stepping order, tacho and watchdog relations.
// Assumes one clock with a synchronous active-high reset; bound to the sequencer top below.
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer_chk (
    input wire logic i_sys_clk,          // Clock.
    input wire logic i_rst,              // Reset, active high.
    input wire logic i_brake,            // Brake request.
    input wire logic i_hold_reset,       // Sequence hold.
    input wire logic i_dir,              // Direction.
    input wire logic o_phase_out_a,      // Level a.
    input wire logic o_phase_out_a_oe_n, // Enable a, low while driven.
    input wire logic o_phase_out_b,      // Level b.
    input wire logic o_phase_out_b_oe_n, // Enable b, low while driven.
    input wire logic o_phase_out_c,      // Level c.
    input wire logic o_phase_out_c_oe_n, // Enable c, low while driven.
    input wire logic o_tacho_toggle_out, // Tacho level.
    input wire logic o_commutate,        // Advance pulse.
    input wire logic o_watchdog_expired  // Watchdog level.
);
    logic [1:0] toggles_ff;

    // Enables then masked levels, so a floating phase always reads as level zero.
    wire logic [5:0] code = {o_phase_out_a_oe_n, o_phase_out_b_oe_n, o_phase_out_c_oe_n,
        o_phase_out_a & ~o_phase_out_a_oe_n, o_phase_out_b & ~o_phase_out_b_oe_n,
        o_phase_out_c & ~o_phase_out_c_oe_n};

    // Forward successor of a code; five forward steps give the reverse successor.
    function automatic logic [5:0] fwd(input logic [5:0] c);
        case (c)
            6'h21: fwd = 6'h0C;
            6'h0C: fwd = 6'h14;
            6'h14: fwd = 6'h22;
            6'h22: fwd = 6'h0A;
            6'h0A: fwd = 6'h11;
            default: fwd = 6'h21;
        endcase
    endfunction

    // Counts tacho edges within one commutation period; a second edge would be a double detection.
    always @(posedge i_sys_clk) begin
        if (i_rst || i_hold_reset || o_commutate) begin
            toggles_ff <= 2'h0;
        end else if ($changed(o_tacho_toggle_out) && toggles_ff != 2'h3) begin
            toggles_ff <= toggles_ff + 2'h1;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // Output relations to their causes at the inputs.
    brake_all_low_a: assert property (i_brake |=> code == 6'h00)
        else $error("brake did not drive all phases low");
    hold_state_one_a: assert property (i_hold_reset && !i_brake |=> code == 6'h21)
        else $error("hold did not give state one");
    legal_code_a: assert property (code inside {6'h21, 6'h0C, 6'h14, 6'h22, 6'h0A, 6'h11, 6'h00})
        else $error("phase outputs outside the six states");
    step_forward_a: assert property (o_commutate && !i_dir && !i_brake && !i_hold_reset && code != 6'h00
        |=> code == fwd($past(code))) else $error("forward step wrong");
    step_reverse_a: assert property (o_commutate && i_dir && !i_brake && !i_hold_reset && code != 6'h00
        |=> code == fwd(fwd(fwd(fwd(fwd($past(code))))))) else $error("reverse step wrong");
    steady_between_a: assert property (!o_commutate && !i_brake && !i_hold_reset && code != 6'h00
        |=> $stable(code)) else $error("phase outputs moved without a commutation");
    tacho_gated_a: assert property ($changed(o_tacho_toggle_out) && !$past(i_hold_reset)
        |-> !$past(o_watchdog_expired)) else $error("tacho toggled after watchdog expiry");
    tacho_once_a: assert property (toggles_ff < 2'h2)
        else $error("tacho toggled twice in one period");
    wdog_sticky_a: assert property (o_watchdog_expired && !o_commutate && !i_hold_reset && !i_brake
        |=> o_watchdog_expired) else $error("watchdog expiry dropped mid period");

    // Main scenarios.
    cover property (o_commutate && o_watchdog_expired);
    cover property (o_commutate && i_dir);
    cover property (i_brake && i_hold_reset);
endmodule

bind scs_sequencer scs_sequencer_chk i_chk (.i_sys_clk, .i_rst, .i_brake, .i_hold_reset, .i_dir,
    .o_phase_out_a, .o_phase_out_a_oe_n, .o_phase_out_b, .o_phase_out_b_oe_n, .o_phase_out_c,
    .o_phase_out_c_oe_n, .o_tacho_toggle_out, .o_commutate, .o_watchdog_expired);

`default_nettype wire

// File: tb/scs_motor_model.sv
// Behavioural motor windings: flyback pulse and back-EMF comparator levels.
// Assumes the drive code is enables then masked levels of phases a, b and c.
`timescale 1ns/1ps
`default_nettype none

module scs_motor_model (
    input  wire logic       i_sys_clk, // Clock.
    input  wire logic       i_spin,    // High: rotor turns and makes EMF.
    input  wire logic       i_dir,     // Direction level.
    input  wire logic       i_hold,    // Sequence hold restarts the period.
    input  wire logic [5:0] i_code,    // Observed drive code.
    output logic            o_flyback, // Flyback pulse.
    output logic            o_emf_a,   // Comparator a.
    output logic            o_emf_b,   // Comparator b.
    output logic            o_emf_c    // Comparator c.
);
    logic [5:0] last_ff = 6'h00;
    logic [5:0] cnt_ff  = 6'h3F;
    logic       tick_ff = 1'b0;
    logic       odd;
    logic       al;
    logic       fl;

    // Odd states give the rising polarity; direction flips it.
    assign odd = i_code[5] ? i_code[0] : (i_code[3] ? ~i_code[2] : i_code[2]);
    assign al  = odd ^ i_dir;
    // Spinning: diode polarity, then recovery, then the crossing; stalled: diode polarity stays.
    assign fl  = (i_spin && cnt_ff >= 6'h0A && cnt_ff < 6'h18) ? ~al : al;
    assign o_flyback = cnt_ff < 6'h03;
    // Driven phases show a level that changes every cycle, so only the floating one is usable.
    assign o_emf_a = i_code[5] ? fl : tick_ff;
    assign o_emf_b = i_code[4] ? fl : tick_ff;
    assign o_emf_c = i_code[3] ? fl : tick_ff;

    // Times the period from each drive change.
    always @(posedge i_sys_clk) begin
        last_ff <= i_code;
        tick_ff <= ~tick_ff;
        if (i_hold || i_code != last_ff) begin
            cnt_ff <= 6'h00;
        end else if (cnt_ff != 6'h3F) begin
            cnt_ff <= cnt_ff + 6'h01;
        end
    end
endmodule

`default_nettype wire

// File: tb/scs_sequencer_tb_top.sv
// Testbench of the sequencer: brake, hold, forward and reverse running, stalled start-up.
// Assumes the motor model on the far side and a fast start oscillator parameter.
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer_tb_top;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_brake = 1'b0;
    logic i_hold_reset = 1'b0;
    logic i_dir = 1'b0;
    logic spin = 1'b1;
    wire logic i_flyback, i_emf_a, i_emf_b, i_emf_c;
    wire logic o_phase_out_a, o_phase_out_a_oe_n, o_phase_out_b, o_phase_out_b_oe_n;
    wire logic o_phase_out_c, o_phase_out_c_oe_n, o_tacho_toggle_out, o_commutate, o_watchdog_expired;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [5:0] codes [6] = '{6'h21, 6'h0C, 6'h14, 6'h22, 6'h0A, 6'h11};
    wire logic [5:0] seen = {o_phase_out_a_oe_n, o_phase_out_b_oe_n, o_phase_out_c_oe_n,
        o_phase_out_a & ~o_phase_out_a_oe_n, o_phase_out_b & ~o_phase_out_b_oe_n,
        o_phase_out_c & ~o_phase_out_c_oe_n};

    scs_sequencer #(.ST_STEP(12'h00A)) i_dut (.i_sys_clk, .i_rst, .i_brake, .i_hold_reset, .i_dir,
        .i_flyback, .i_emf_a, .i_emf_b, .i_emf_c, .o_phase_out_a, .o_phase_out_a_oe_n,
        .o_phase_out_b, .o_phase_out_b_oe_n, .o_phase_out_c, .o_phase_out_c_oe_n,
        .o_tacho_toggle_out, .o_commutate, .o_watchdog_expired);
    scs_motor_model i_motor (.i_sys_clk, .i_spin(spin), .i_dir, .i_hold(i_hold_reset), .i_code(seen),
        .o_flyback(i_flyback), .o_emf_a(i_emf_a), .o_emf_b(i_emf_b), .o_emf_c(i_emf_c));

    // Clock of 20 ns period.
    always #10 i_sys_clk = ~i_sys_clk;

    // Cuts a hang short.
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 12000) begin
            mismatches++;
            results();
        end
    end

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Drives the control inputs and waits until the registered outputs follow.
    task automatic drive(input logic b, input logic h, input logic d, input logic s);
        @(posedge i_sys_clk);
        i_brake <= b;
        i_hold_reset <= h;
        i_dir <= d;
        spin <= s;
        repeat (2) @(negedge i_sys_clk);
    endtask

    // Holds state one, releases, then follows the given number of steps.
    task automatic run(input logic d, input logic s, input int steps);
        int idx;
        int n;
        logic tach;
        idx = 0;
        drive(1'b0, 1'b1, d, s);
        chk("held code", codes[0], seen);
        drive(1'b0, 1'b0, d, s);
        for (int i = 0; i < steps; i++) begin
            tach = o_tacho_toggle_out;
            n = 0;
            while (n < 1000 && o_commutate !== 1'b1) begin
                @(negedge i_sys_clk);
                n++;
            end
            chk("step pulse", 6'h01, {5'h00, o_commutate});
            if (!s) begin
                chk("watchdog", 6'h01, {5'h00, o_watchdog_expired});
                chk("tacho still", {5'h00, tach}, {5'h00, o_tacho_toggle_out});
            end else if (i > 0) begin
                chk("tacho toggle", {5'h00, ~tach}, {5'h00, o_tacho_toggle_out});
            end
            idx = d ? (idx + 5) % 6 : (idx + 1) % 6;
            @(negedge i_sys_clk);
            chk("phase code", codes[idx], seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(negedge i_sys_clk);
        chk("reset code", codes[0], seen);
        drive(1'b1, 1'b0, 1'b0, 1'b1);
        chk("brake code", 6'h00, seen);
        drive(1'b1, 1'b1, 1'b0, 1'b1);
        chk("brake over hold", 6'h00, seen);
        $display("test brake done");
        run(1'b0, 1'b1, 7);
        $display("test forward done");
        run(1'b1, 1'b1, 7);
        $display("test reverse done");
        run(1'b0, 1'b0, 3);
        run(1'b1, 1'b0, 2);
        $display("test stalled start done");
        results();
    end
endmodule

`default_nettype wire
